// [src/brs_pkg.sv]
// Constants and types shared by the bus reset and standby sequencer.
// Assumes a core clock at twice the system clock rate, so one bus state is two core cycles.
package brs_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CORE_CLK_NS    = 50;
   localparam int CORE_PER_SYS   = 2;
   localparam int HW_STANDBY_N_LEAD_SYS  = 10;
   localparam int HW_STANDBY_N_LEAD_CYC  = HW_STANDBY_N_LEAD_SYS * CORE_PER_SYS;
   localparam int EXIT_LEAD_NS   = 100;
   localparam int EXIT_LEAD_CYC  = (EXIT_LEAD_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int CNT_W          = 5;
   localparam logic [CNT_W-1:0] HW_STANDBY_N_LEAD_CNT = CNT_W'(HW_STANDBY_N_LEAD_CYC);
   localparam logic [CNT_W-1:0] EXIT_LEAD_CNT = CNT_W'(EXIT_LEAD_CYC);

   // ----------------------------------------------------------------
   // System clock phase: the high half, then the low half
   // ----------------------------------------------------------------
   localparam logic PH_HIGH = 1'b0;
   localparam logic PH_LOW  = 1'b1;

   // ----------------------------------------------------------------
   // Bus states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_T1   = 3'h1,
      ST_T2   = 3'h3,
      ST_TW   = 3'h2,
      ST_T3   = 3'h6,
      ST_HOLD = 3'h7,
      ST_HALT = 3'h4,
      ST_HW_STANDBY_N = 3'h5
   } brs_state_t;

endpackage : brs_pkg

// [src/brs_sync.sv]
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous levels; each bit is caught on its own.
`timescale 1ns/1ps
module brs_sync #(
   parameter int               WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT  = '0
) (
   // Clock and reset
   input  wire logic             core_clk_in,
   input  wire logic             rst_n_in,
   // Pins and synchronised copy
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   // ----------------------------------------------------------------
   // Stages; the first is read by the second only
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         meta     <= INIT;
         sync_out <= INIT;
      end
      else
      begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : brs_sync

// [src/brs_bus_reset_seq.sv]
// External bus cycle engine with reset abort and hardware standby sequencing.
// Assumes the board drives chip_init_n and hw_standby_n asynchronously, and a user requests accesses.
`timescale 1ns/1ps
module brs_bus_reset_seq #(
   parameter int ADDR_W = 24,
   parameter int DATA_W = 16,
   parameter int WAIT_W = 2
) (
   // Clock and reset
   input  wire logic              core_clk_in,
   input  wire logic              rst_n_in,
   // Board control pins
   input  wire logic              chip_init_n_in,
   input  wire logic              hw_standby_n_in,
   input  wire logic              onchip_ram_enable_in,
   // Access request
   input  wire logic              req_in,
   input  wire logic              write_in,
   input  wire logic              upper_en_in,
   input  wire logic              lower_en_in,
   input  wire logic              two_state_in,
   input  wire logic [WAIT_W-1:0] wait_states_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [DATA_W-1:0] wdata_in,
   output logic                   busy_out,
   output logic                   done_out,
   output logic      [DATA_W-1:0] rdata_out,
   // External bus pins
   output logic                   sys_clk_out,
   output logic      [ADDR_W-1:0] addr_out,
   output logic                   addr_oe_out,
   output logic                   addr_strobe_n_out,
   output logic                   read_n_out,
   output logic                   upper_byte_write_n_out,
   output logic                   lower_byte_write_n_out,
   input  wire logic [DATA_W-1:0] data_in,
   output logic      [DATA_W-1:0] data_out,
   output logic                   data_oe_out,
   output logic                   port_oe_out,
   // Standby status
   output logic                   in_standby_out,
   output logic                   ram_retained_out,
   output logic                   standby_order_err_out
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic              init_s;
   logic              hw_standby_n_s;
   logic [DATA_W-1:0] data_s;

   brs_sync #(
      .WIDTH (DATA_W + 2),
      .INIT  ({2'h3, {DATA_W{1'b0}}})
   ) u_sync (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .async_in    ({chip_init_n_in, hw_standby_n_in, data_in}),
      .sync_out    ({init_s, hw_standby_n_s, data_s})
   );

   // ----------------------------------------------------------------
   // Strobe decode
   // ----------------------------------------------------------------
   // Returns {address strobe, read strobe, write strobe} active high
   function automatic logic [2:0] brs_strobes(input brs_pkg::brs_state_t s, input logic ph, input logic wr);
      logic as_on;
      as_on = ((s == brs_pkg::ST_T1) && (ph == brs_pkg::PH_LOW)) ||
              (s == brs_pkg::ST_T2) || (s == brs_pkg::ST_TW) || (s == brs_pkg::ST_T3);
      return {as_on, as_on & ~wr, wr & as_on & (s != brs_pkg::ST_T1)};
   endfunction : brs_strobes

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   brs_pkg::brs_state_t     state, next_state;
   logic                    ph, next_ph;
   logic                    wr, next_wr;
   logic                    two, next_two;
   logic                    upper, next_upper;
   logic                    lower, next_lower;
   logic [WAIT_W-1:0]       wait_cnt, next_wait_cnt;
   logic [brs_pkg::CNT_W-1:0] init_cnt, next_init_cnt;
   logic [brs_pkg::CNT_W-1:0] exit_cnt, next_exit_cnt;
   logic                    next_busy, next_done, next_addr_oe, next_data_oe, next_port_oe;
   logic                    next_as_n, next_rd_n, next_uw_n, next_lw_n;
   logic                    next_hw_standby_n, next_retained, next_err;
   logic [ADDR_W-1:0]       next_addr;
   logic [DATA_W-1:0]       next_data, next_rdata;
   logic [2:0]              strb;
   logic                    cut_early;
   logic                    cut_late;

   // Access states in which the address must go low half a state after the sample
   assign cut_early = (state == brs_pkg::ST_T1) || (state == brs_pkg::ST_TW) ||
                      ((state == brs_pkg::ST_T2) && !two);
   // Final states, whose address stays until the state ends
   assign cut_late  = (state == brs_pkg::ST_T3) || ((state == brs_pkg::ST_T2) && two);

   always_comb
   begin
      next_state    = state;
      next_ph       = ~ph;
      next_wr       = wr;
      next_two      = two;
      next_upper    = upper;
      next_lower    = lower;
      next_wait_cnt = wait_cnt;
      next_addr     = addr_out;
      next_addr_oe  = addr_oe_out;
      next_data     = data_out;
      next_data_oe  = data_oe_out;
      next_port_oe  = 1'b1;
      next_rdata    = rdata_out;
      next_done     = 1'b0;
      next_retained = ram_retained_out;
      next_err      = standby_order_err_out;
      next_init_cnt = init_s ? '0 : ((init_cnt == brs_pkg::HW_STANDBY_N_LEAD_CNT) ? init_cnt : init_cnt + 1'b1);
      next_exit_cnt = '0;
      strb          = 3'h0;
      if (!hw_standby_n_s)
      begin
         // Standby floats the address, data and port pins; the RAM keeps its contents only after a proper reset lead
         if (state != brs_pkg::ST_HW_STANDBY_N)
         begin
            next_retained = onchip_ram_enable_in && (init_cnt == brs_pkg::HW_STANDBY_N_LEAD_CNT);
            next_err      = 1'b0;
         end
         next_state    = brs_pkg::ST_HW_STANDBY_N;
         next_addr     = '0;
         next_addr_oe  = 1'b0;
         next_data_oe  = 1'b0;
         next_port_oe  = 1'b0;
         next_exit_cnt = (!init_s && exit_cnt != brs_pkg::EXIT_LEAD_CNT) ? exit_cnt + 1'b1 : exit_cnt;
         if (init_s)
            next_exit_cnt = '0;
      end
      else if (state == brs_pkg::ST_HW_STANDBY_N)
      begin
         // Leaving standby without the reset lead is reported, the bus still restarts cleanly
         next_err     = !(exit_cnt == brs_pkg::EXIT_LEAD_CNT && !init_s);
         next_state   = brs_pkg::ST_HALT;
         next_port_oe = 1'b0;
      end
      else if (!init_s)
      begin
         // Pins let go at once; only the address waits for the sampled edge
         next_port_oe = 1'b0;
         next_data_oe = 1'b0;
         if (ph == brs_pkg::PH_HIGH)
         begin
            if (cut_late)
               next_state = brs_pkg::ST_HOLD;
            else
               next_state = brs_pkg::ST_HALT;
            if (cut_early || state == brs_pkg::ST_IDLE || state == brs_pkg::ST_HALT)
               next_addr_oe = 1'b1;
         end
         if (state == brs_pkg::ST_HALT)
            next_addr = '0;
         if (state == brs_pkg::ST_HOLD && ph == brs_pkg::PH_LOW)
         begin
            next_addr  = '0;
            next_state = brs_pkg::ST_HALT;
         end
      end
      else
      begin
         case (state)
            brs_pkg::ST_IDLE:
               if (req_in && ph == brs_pkg::PH_LOW)
               begin
                  next_state    = brs_pkg::ST_T1;
                  next_wr       = write_in;
                  next_two      = two_state_in;
                  next_upper    = upper_en_in;
                  next_lower    = lower_en_in;
                  next_wait_cnt = wait_states_in;
                  next_addr     = addr_in;
                  next_addr_oe  = 1'b1;
                  next_data     = wdata_in;
                  next_data_oe  = write_in;
               end
            brs_pkg::ST_T1:
               if (ph == brs_pkg::PH_LOW)
                  next_state = brs_pkg::ST_T2;
            brs_pkg::ST_T2, brs_pkg::ST_TW, brs_pkg::ST_T3:
               if (ph == brs_pkg::PH_LOW)
               begin
                  if (state == brs_pkg::ST_T3 || (state == brs_pkg::ST_T2 && two))
                  begin
                     next_state   = brs_pkg::ST_IDLE;
                     next_done    = 1'b1;
                     next_data_oe = 1'b0;
                     if (!wr)
                        next_rdata = data_s;
                  end
                  else if (wait_cnt != '0)
                  begin
                     next_state    = brs_pkg::ST_TW;
                     next_wait_cnt = wait_cnt - 1'b1;
                  end
                  else
                     next_state = brs_pkg::ST_T3;
               end
            brs_pkg::ST_HALT, brs_pkg::ST_HOLD:
               if (ph == brs_pkg::PH_LOW)
                  next_state = brs_pkg::ST_IDLE;
            default:
               next_state = brs_pkg::ST_IDLE;
         endcase
         strb = brs_strobes(next_state, next_ph, next_wr);
      end
      // Strobes stay high in every abort path since strb is only set by a live access
      next_as_n = ~strb[2];
      next_rd_n = ~strb[1];
      next_uw_n = ~(strb[0] & next_upper);
      next_lw_n = ~(strb[0] & next_lower);
      next_busy = (next_state != brs_pkg::ST_IDLE);
      next_hw_standby_n = (next_state == brs_pkg::ST_HW_STANDBY_N);
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         state                  <= brs_pkg::ST_IDLE;
         ph                     <= brs_pkg::PH_HIGH;
         wr                     <= 1'b0;
         two                    <= 1'b0;
         upper                  <= 1'b0;
         lower                  <= 1'b0;
         wait_cnt               <= '0;
         init_cnt               <= '0;
         exit_cnt               <= '0;
         busy_out               <= 1'b0;
         done_out               <= 1'b0;
         rdata_out              <= '0;
         sys_clk_out            <= 1'b1;
         addr_out               <= '0;
         addr_oe_out            <= 1'b0;
         addr_strobe_n_out      <= 1'b1;
         read_n_out             <= 1'b1;
         upper_byte_write_n_out <= 1'b1;
         lower_byte_write_n_out <= 1'b1;
         data_out               <= '0;
         data_oe_out            <= 1'b0;
         port_oe_out            <= 1'b0;
         in_standby_out         <= 1'b0;
         ram_retained_out       <= 1'b0;
         standby_order_err_out  <= 1'b0;
      end
      else
      begin
         state                  <= next_state;
         ph                     <= next_ph;
         wr                     <= next_wr;
         two                    <= next_two;
         upper                  <= next_upper;
         lower                  <= next_lower;
         wait_cnt               <= next_wait_cnt;
         init_cnt               <= next_init_cnt;
         exit_cnt               <= next_exit_cnt;
         busy_out               <= next_busy;
         done_out               <= next_done;
         rdata_out              <= next_rdata;
         sys_clk_out            <= (next_ph == brs_pkg::PH_HIGH);
         addr_out               <= next_addr;
         addr_oe_out            <= next_addr_oe;
         addr_strobe_n_out      <= next_as_n;
         read_n_out             <= next_rd_n;
         upper_byte_write_n_out <= next_uw_n;
         lower_byte_write_n_out <= next_lw_n;
         data_out               <= next_data;
         data_oe_out            <= next_data_oe;
         port_oe_out            <= next_port_oe;
         in_standby_out         <= next_hw_standby_n;
         ram_retained_out       <= next_retained;
         standby_order_err_out  <= next_err;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_ports_input: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !init_s |=> !port_oe_out) else $error("ports not input under reset");
   a_strobes_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !init_s |=> (addr_strobe_n_out && read_n_out && upper_byte_write_n_out &&
                   lower_byte_write_n_out && !data_oe_out)) else $error("strobe or data active under reset");
   a_addr_early: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (hw_standby_n_s && !init_s && ph == brs_pkg::PH_HIGH && (state == brs_pkg::ST_T1 ||
       (state == brs_pkg::ST_T2 && !two))) |=> ##1 (addr_out == '0)) else $error("address not low after sample");
   a_sample_edge: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (hw_standby_n_s && !init_s && ph == brs_pkg::PH_LOW && (state == brs_pkg::ST_T1 || state == brs_pkg::ST_T3))
      |=> (state == $past(state))) else $error("reset taken off the falling edge");
   a_wait_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (hw_standby_n_s && !init_s && ph == brs_pkg::PH_HIGH && state == brs_pkg::ST_TW)
      |=> state == brs_pkg::ST_HALT ##1 (addr_out == '0)) else $error("wait state reset timing wrong");
   a_addr_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (hw_standby_n_s && !init_s && ph == brs_pkg::PH_HIGH && state == brs_pkg::ST_T3)
      |=> (state == brs_pkg::ST_HOLD && addr_out == $past(addr_out))) else $error("address not held in third state");
   a_two_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (hw_standby_n_s && !init_s && ph == brs_pkg::PH_HIGH && state == brs_pkg::ST_T2 && two)
      |=> (state == brs_pkg::ST_HOLD && addr_out == $past(addr_out))) else $error("two-state address not held");
   a_no_strobe: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state == brs_pkg::ST_HALT || state == brs_pkg::ST_HOLD) |=>
      (addr_strobe_n_out && read_n_out && upper_byte_write_n_out && lower_byte_write_n_out))
      else $error("strobe after abandoned access");

endmodule : brs_bus_reset_seq

// [tb/brs_partner.sv]
// Board-side model: external memory plus the board reset and standby controller.
// Assumes the bench calls its tasks just after a falling core clock edge.
`timescale 1ns/1ps
module brs_partner #(
   parameter int ADDR_W = 24,
   parameter int DATA_W = 16
) (
   // Clock
   input  wire logic              core_clk_in,
   // Bus pins from the design
   input  wire logic              addr_strobe_n_in,
   input  wire logic              read_n_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   // Pins driven by the board
   output logic      [DATA_W-1:0] data_out,
   output logic                   chip_init_n_out,
   output logic                   hw_standby_n_out
);
   // ------------------------------------------------------------
   // Memory
   // ------------------------------------------------------------
   initial
   begin
      data_out         = '0;
      chip_init_n_out  = 1'b1;
      hw_standby_n_out = 1'b1;
   end

   // Released bus toggles every cycle so a late sample cannot pass by luck
   always @(negedge core_clk_in)
   begin
      if (!addr_strobe_n_in && !read_n_in)
         data_out <= addr_in[DATA_W-1:0] ^ DATA_W'(16'h5a3c);
      else
         data_out <= ~data_out;
   end

   // ------------------------------------------------------------
   // Board controller
   // ------------------------------------------------------------
   task automatic set_init(input logic level);
      chip_init_n_out = level;
   endtask : set_init

   task automatic enter_standby(input logic lead);
      if (lead)
      begin
         chip_init_n_out = 1'b0;
         repeat (brs_pkg::HW_STANDBY_N_LEAD_CYC) @(negedge core_clk_in); // Ten system clocks
      end
      hw_standby_n_out = 1'b0;             // No lead needed without retention
   endtask : enter_standby                 // Reset left low past standby entry when a lead is given

   task automatic leave_standby(input logic lead);
      if (lead)
      begin
         chip_init_n_out = 1'b0;
         repeat (brs_pkg::EXIT_LEAD_CYC) @(negedge core_clk_in); // Lead of 100 ns
      end
      hw_standby_n_out = 1'b1;
      repeat (4) @(negedge core_clk_in);
      chip_init_n_out = 1'b1;
   endtask : leave_standby
endmodule : brs_partner

// [tb/test_bus_reset_standby_sequencing.sv]
// Self-checking bench for the bus reset and standby sequencer.
// Assumes the board model drives reset, standby and the data pins.
`timescale 1ns/1ps
module test_bus_reset_standby_sequencing;
   logic        core_clk_in, rst_n_in, ram_en, req, wr, up_en, lo_en, two;
   logic        busy, done, sys_clk, addr_oe, addr_strobe_n, read_n, uw_n, lw_n;
   logic        data_oe, port_oe, in_hw_standby_n, ram_ret, order_err, chip_init_n, hw_standby_n;
   logic [1:0]  waits;
   logic [23:0] addr, addr_pin;
   logic [15:0] wdata, rdata, data_in, data_pin;
   int          errors, checked, cycles;

   brs_bus_reset_seq dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .chip_init_n_in(chip_init_n),
      .hw_standby_n_in(hw_standby_n), .onchip_ram_enable_in(ram_en), .req_in(req), .write_in(wr),
      .upper_en_in(up_en), .lower_en_in(lo_en), .two_state_in(two), .wait_states_in(waits),
      .addr_in(addr), .wdata_in(wdata), .busy_out(busy), .done_out(done), .rdata_out(rdata),
      .sys_clk_out(sys_clk), .addr_out(addr_pin), .addr_oe_out(addr_oe), .addr_strobe_n_out(addr_strobe_n),
      .read_n_out(read_n), .upper_byte_write_n_out(uw_n), .lower_byte_write_n_out(lw_n),
      .data_in(data_in), .data_out(data_pin), .data_oe_out(data_oe), .port_oe_out(port_oe),
      .in_standby_out(in_hw_standby_n), .ram_retained_out(ram_ret), .standby_order_err_out(order_err));

   brs_partner u_partner (.core_clk_in(core_clk_in), .addr_strobe_n_in(addr_strobe_n), .read_n_in(read_n),
      .addr_in(addr_pin), .data_out(data_in), .chip_init_n_out(chip_init_n), .hw_standby_n_out(hw_standby_n));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic tick();
      @(negedge core_clk_in);
   endtask : tick

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic quiet_now();
      return addr_strobe_n === 1'b1 && read_n === 1'b1 && uw_n === 1'b1 && lw_n === 1'b1 && done !== 1'b1;
   endfunction : quiet_now

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   task automatic start_req(input logic w, input logic t, input logic [1:0] ws, input logic [23:0] a);
      int n;
      tick();
      wr    = w;
      two   = t;
      waits = ws;
      addr  = a;
      wdata = ~a[15:0];
      up_en = 1'b1;
      lo_en = !t;
      req   = 1'b1;
      for (n = 0; busy !== 1'b1 && n < 10; n++) tick();
      req = 1'b0;
      check(32'(busy), 32'h1);
   endtask : start_req

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic run_access(input logic w, input logic t, input logic [1:0] ws, input logic [23:0] a);
      int n;
      start_req(w, t, ws, a);
      check({27'h0, sys_clk, addr_strobe_n, data_oe, addr_oe, busy}, {27'h0, 1'b1, 1'b1, w, 1'b1, 1'b1});
      check(32'(addr_pin), 32'(a));
      if (w)
         check(32'(data_pin), {16'h0, ~a[15:0]});
      tick();
      check({29'h0, sys_clk, addr_strobe_n, read_n}, {29'h0, 1'b0, 1'b0, w});
      for (n = 1; done !== 1'b1 && n < 40; n++) tick();
      check(32'(n), t ? 32'd4 : 32'(6 + 2 * ws));
      if (!w)
         check(32'(rdata), 32'(a[15:0] ^ 16'h5a3c));
   endtask : run_access

   // Reset lands after d cycles into the access; the access must be dropped
   task automatic abort_access(input logic w, input logic t, input logic [1:0] ws, input logic [23:0] a,
                               input int d);
      int   n;
      logic quiet;
      quiet = 1'b1;
      start_req(w, t, ws, a);
      repeat (d) tick();
      u_partner.set_init(1'b0);
      for (n = 0; port_oe !== 1'b0 && n < 6; n++)
      begin
         tick();
         quiet &= (done !== 1'b1);
      end
      check(32'(n <= 4), 32'h1);
      check({28'h0, addr_strobe_n, read_n, uw_n, lw_n}, 32'hf);
      check(32'(data_oe), 32'h0);
      check(32'(addr_pin), 32'(a));
      for (n = 0; !(addr_pin === 24'h0 && addr_oe === 1'b1) && n < 6; n++) tick();
      check(32'(n <= 4), 32'h1);
      repeat (4)
      begin
         tick();
         quiet &= quiet_now();
      end
      u_partner.set_init(1'b1);
      repeat (8)
      begin
         tick();
         quiet &= quiet_now();
      end
      check(32'(quiet), 32'h1);
      check(32'(busy), 32'h0);
   endtask : abort_access

   task automatic standby(input logic lead_in, input logic ram, input logic lead_out);
      int n;
      tick();
      ram_en = ram;
      u_partner.enter_standby(lead_in);
      for (n = 0; in_hw_standby_n !== 1'b1 && n < 8; n++) tick();
      check(32'(in_hw_standby_n), 32'h1);
      check(32'(ram_ret), 32'(ram & lead_in));
      check({29'h0, port_oe, addr_oe, data_oe}, 32'h0);
      check(32'(addr_pin), 32'h0);
      req = 1'b1;
      repeat (4) tick();
      check({28'h0, busy, addr_strobe_n, addr_oe, done}, 32'hc);
      req = 1'b0;
      u_partner.leave_standby(lead_out);
      for (n = 0; in_hw_standby_n !== 1'b0 && n < 8; n++) tick();
      check(32'(in_hw_standby_n), 32'h0);
      check(32'(order_err), 32'(!lead_out));
      repeat (6) tick();
   endtask : standby

   // ------------------------------------------------------------
   // Clock, timeout and main sequence
   // ------------------------------------------------------------
   initial
   begin
      core_clk_in = 1'b0;
      forever #25 core_clk_in = ~core_clk_in;
   end

   always @(posedge core_clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         report_and_stop();
      end
   end

   initial
   begin
      {rst_n_in, ram_en, req, wr, up_en, lo_en, two, waits, addr, wdata} = '0;
      errors  = 0;
      checked = 0;
      cycles  = 0;
      repeat (20) tick();
      rst_n_in = 1'b1;
      run_access(1'b0, 1'b0, 2'h0, 24'h01a2b3);
      run_access(1'b1, 1'b0, 2'h3, 24'hfedcb8);
      run_access(1'b0, 1'b1, 2'h0, 24'h80f00e);
      run_access(1'b1, 1'b1, 2'h1, 24'h000002);
      for (int d = 0; d < 6; d++)
         abort_access(d[0], 1'b0, 2'h2, 24'h5c0001 + 24'(d), d);
      abort_access(1'b0, 1'b1, 2'h0, 24'h3c3c3c, 0);
      abort_access(1'b1, 1'b1, 2'h0, 24'hc3c3c2, 0);
      // Reset seen in the third state, on both halves of it
      for (int d = 2; d < 4; d++)
         abort_access(d[0], 1'b0, 2'h0, 24'h0a0b0c + 24'(d), d);
      run_access(1'b0, 1'b0, 2'h1, 24'h123456);
      standby(1'b1, 1'b1, 1'b1);
      standby(1'b0, 1'b1, 1'b0);
      standby(1'b1, 1'b0, 1'b1);
      report_and_stop();
   end
endmodule : test_bus_reset_standby_sequencing
